// >>> rfe_line_encoder.sv
// Summary of operation
// RULE1: serialise each byte, MSB first
// RULE2: loading byte starts encoding, amplifier on
// RULE3: amplifier follows transmission when manual bit clear
// RULE4: output advances only on divider strobe
// RULE5: three-bit field picks one of six codes
// RULE6: raw mode one chip per bit
// RULE7: idle level bit sets output outside transmission; here only with the manual amplifier bit set, else output is the invert bit
// RULE8: invert bit inverts encoder output
// RULE9: length field plus one bits sent
// RULE10: buffer-full flag while byte not taken
// RULE11: feeder never writes while buffer full
// RULE12: shift-end flag after last bit
// RULE13: monitors cut amplifier on lock/crystal fail; here only while a byte is pending or being shifted
// RULE14: amplifier-cut status bit set on cut
// RULE15: monitors disabled after reset
// RULE16: carrier word is integer plus fraction
// RULE17: modulator emits divider ratio stream
// RULE18: byte from sequencer or cpu legacy mode
// RULE19: divisor sixteen bits, rate from divisor
// RULE20: chip rate twice bit rate
// RULE21: encoded output drives frequency select
// RULE22: buffer-full clears on transfer to shifter
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module rfe_line_encoder #(
  parameter int ADDR_W = 8
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // transmission_sequencer byte port
  input  wire logic              seq_load,
  input  wire logic [7:0]        seq_byte,
  output logic                   buffer_full_flag,
  output logic                   shift_end_flag,
  // pll and crystal monitors
  input  wire logic              lock_lost_flag,
  input  wire logic              crystal_fail_flag,
  // rf front end
  output logic                   mod_data,
  output logic                   amp_on,
  output logic                   amp_cut_flag,
  output logic [8:0]             ratio_word
);

  if (ADDR_W < 8)
  begin : g_chk
    $error("rfe_line_encoder: ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic [7:0]                   tx_byte;
    logic [7:0]                   enc_cfg;
    logic [3:0]                   control;
    logic                         full;
    logic                         shift_end;
    logic                         cut;
    logic [rfe_pkg::BAUD_W-1:0]   baud_div;
    logic [rfe_pkg::INT_W-1:0]    freq_int;
    logic [rfe_pkg::FRAC_W-1:0]   freq_frc;
    rfe_pkg::rfe_enc_type         enc;
    logic [7:0]                   shifter;
    logic [2:0]                   left;
    logic                         half;
    logic                         level;
    logic                         mod;
    logic                         amp;
    logic [31:0]                  rdata;
    logic                         ready;
    logic                         err;
    logic                         last;
  } rfe_state_type;

  rfe_state_type st_reg;
  rfe_state_type st_next;
  logic          chip_tick;
  logic          acc_done;
  logic          wr;
  logic          cpu_mode;
  logic [2:0]    scheme;
  logic          b;
  logic          chip;
  logic          bit_end;
  logic          mapped;
  logic          fail;
  logic [7:0]    off;

  rfe_baud_gen #(
    .DIV_W (rfe_pkg::BAUD_W)
  ) u_baud (
    .pclk      (pclk),
    .presetn   (presetn),
    .divisor   (st_reg.baud_div), // [RULE19]
    .chip_tick (chip_tick)        // [RULE20]
  );

  rfe_sd_mod #(
    .INT_W  (rfe_pkg::INT_W),
    .FRAC_W (rfe_pkg::FRAC_W)
  ) u_sd (
    .pclk       (pclk),
    .presetn    (presetn),
    .int_word   (st_reg.freq_int), // [RULE16]
    .frac_word  (st_reg.freq_frc), // [RULE16]
    .ratio_word (ratio_word)
  );

  assign off      = paddr[7:0];
  assign acc_done = psel & penable & st_reg.ready;
  assign wr       = acc_done & pwrite;
  assign cpu_mode = st_reg.control[rfe_pkg::CTL_CPU_MODE];
  assign scheme   = st_reg.enc_cfg[rfe_pkg::ENC_SCHEME_LSB +: 3];
  assign b        = st_reg.shifter[7];
  assign fail     = (st_reg.control[rfe_pkg::CTL_LOCK_MON]
                     & lock_lost_flag)
                  | (st_reg.control[rfe_pkg::CTL_XTAL_MON]
                     & crystal_fail_flag);
  assign mapped   = (off == rfe_pkg::OFF_TX_BYTE)
                  | (off == rfe_pkg::OFF_ENC_CFG)
                  | (off == rfe_pkg::OFF_CONTROL)
                  | (off == rfe_pkg::OFF_STATUS)
                  | (off == rfe_pkg::OFF_BAUD_DIV)
                  | (off == rfe_pkg::OFF_FREQ_INT)
                  | (off == rfe_pkg::OFF_FREQ_FRC);

  // line code of the current chip
  always_comb
  begin
    chip = b;
    bit_end = st_reg.half;
    case (scheme) // [RULE5]
      rfe_pkg::SCH_INV_MANCH:
        chip = st_reg.half ? b : ~b;
      rfe_pkg::SCH_DIFF:
        chip = st_reg.half ? ~st_reg.level
                           : (b ? st_reg.level : ~st_reg.level);
      rfe_pkg::SCH_BIPH0:
        chip = st_reg.half ? (b ? ~st_reg.level : st_reg.level)
                           : ~st_reg.level;
      rfe_pkg::SCH_BIPH1:
        chip = st_reg.half ? (b ? st_reg.level : ~st_reg.level)
                           : ~st_reg.level;
      rfe_pkg::SCH_RAW:
      begin
        chip = b;
        bit_end = 1'b1; // [RULE6]
      end
      default:
        chip = st_reg.half ? ~b : b;
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    // apb: one wait state, read data taken from the register
    st_next.ready = psel & penable & ~st_reg.ready;
    st_next.err   = psel & penable & ~st_reg.ready & ~mapped;
    if (psel & penable & ~st_reg.ready)
    begin
      st_next.rdata = '0;
      case (off)
        rfe_pkg::OFF_TX_BYTE:  st_next.rdata[7:0] = st_reg.tx_byte;
        rfe_pkg::OFF_ENC_CFG:  st_next.rdata[7:0] = st_reg.enc_cfg;
        rfe_pkg::OFF_CONTROL:  st_next.rdata[3:0] = st_reg.control;
        rfe_pkg::OFF_STATUS:
        begin
          st_next.rdata[rfe_pkg::STS_FULL]      = st_reg.full;
          st_next.rdata[rfe_pkg::STS_SHIFT_END] = st_reg.shift_end;
          st_next.rdata[rfe_pkg::STS_AMP_CUT]   = st_reg.cut;
          st_next.rdata[rfe_pkg::STS_LOCK_LOST] = lock_lost_flag;
          st_next.rdata[rfe_pkg::STS_XTAL_FAIL] = crystal_fail_flag;
        end
        rfe_pkg::OFF_BAUD_DIV: st_next.rdata[15:0] = st_reg.baud_div;
        rfe_pkg::OFF_FREQ_INT: st_next.rdata[7:0] = st_reg.freq_int;
        rfe_pkg::OFF_FREQ_FRC: st_next.rdata[20:0] = st_reg.freq_frc;
        default:               st_next.rdata = '0;
      endcase
    end
    // register writes
    if (wr)
    begin
      case (off)
        rfe_pkg::OFF_ENC_CFG:  st_next.enc_cfg = pwdata[7:0];
        rfe_pkg::OFF_CONTROL:  st_next.control = pwdata[3:0];
        rfe_pkg::OFF_BAUD_DIV: st_next.baud_div = pwdata[15:0];
        rfe_pkg::OFF_FREQ_INT: st_next.freq_int = pwdata[7:0];
        rfe_pkg::OFF_FREQ_FRC: st_next.freq_frc = pwdata[20:0];
        rfe_pkg::OFF_STATUS:
        begin
          // write one to clear
          if (pwdata[rfe_pkg::STS_SHIFT_END])
            st_next.shift_end = 1'b0;
          if (pwdata[rfe_pkg::STS_AMP_CUT])
            st_next.cut = 1'b0;
        end
        default:
          st_next.tx_byte = st_reg.tx_byte;
      endcase
    end
    // byte load from cpu or sequencer
    if (wr && off == rfe_pkg::OFF_TX_BYTE && cpu_mode)
    begin
      st_next.tx_byte = pwdata[7:0]; // [RULE18]
      st_next.full = 1'b1;           // [RULE10]
    end
    else if (seq_load && !cpu_mode)
    begin
      st_next.tx_byte = seq_byte;    // [RULE18] [RULE11]
      st_next.full = 1'b1;           // [RULE10]
    end
    // encoder, advanced only by the chip strobe
    if (chip_tick) // [RULE4]
    begin
      case (st_reg.enc)
        rfe_pkg::ENC_IDLE:
        begin
          if (st_reg.full)
          begin
            st_next.shifter = st_reg.tx_byte;
            st_next.left = st_reg.enc_cfg[rfe_pkg::ENC_COUNT_LSB +: 3];
            st_next.half = 1'b0;
            st_next.full = 1'b0;              // [RULE22]
            st_next.enc = rfe_pkg::ENC_SHIFT; // [RULE2]
          end
        end
        rfe_pkg::ENC_SHIFT:
        begin
          if (st_reg.last)
          begin
            // last chip has stood a full period
            st_next.last = 1'b0;
            st_next.enc = rfe_pkg::ENC_IDLE;
            st_next.shift_end = 1'b1; // [RULE12]
          end
          else
          begin
            st_next.level = chip;
            st_next.half = ~st_reg.half & ~bit_end;
          end
          if (bit_end && !st_reg.last)
          begin
            st_next.shifter = {st_reg.shifter[6:0], 1'b0}; // [RULE1]
            st_next.left = st_reg.left - 3'h1;            // [RULE9]
            if (st_reg.left == 3'h0)
            begin
              if (st_reg.full)
              begin
                st_next.shifter = st_reg.tx_byte;
                st_next.left =
                  st_reg.enc_cfg[rfe_pkg::ENC_COUNT_LSB +: 3];
                st_next.full = 1'b0; // [RULE22]
              end
              else
                st_next.last = 1'b1;
            end
          end
        end
        default:
          st_next.enc = rfe_pkg::ENC_IDLE;
      endcase
    end
    // monitor cut, set wins over software clear
    if (fail && (st_reg.enc == rfe_pkg::ENC_SHIFT || st_reg.full))
      st_next.cut = 1'b1; // [RULE13] [RULE14]
    // output level and amplifier
    if (st_reg.enc == rfe_pkg::ENC_SHIFT
        && st_next.enc == rfe_pkg::ENC_SHIFT)
      st_next.mod = st_reg.mod;
    else if (st_reg.control[rfe_pkg::CTL_AMP_MANUAL])
      st_next.mod = st_reg.enc_cfg[rfe_pkg::ENC_IDLE_BIT]
                  ^ st_reg.enc_cfg[rfe_pkg::ENC_INVERT_BIT]; // [RULE7]
    else
      st_next.mod = st_reg.enc_cfg[rfe_pkg::ENC_INVERT_BIT];
    if (chip_tick && st_reg.enc == rfe_pkg::ENC_SHIFT
        && st_next.enc == rfe_pkg::ENC_SHIFT)
      st_next.mod = chip ^ st_reg.enc_cfg[rfe_pkg::ENC_INVERT_BIT]; // [RULE8]
    st_next.amp = ~st_next.cut
                & (st_next.control[rfe_pkg::CTL_AMP_MANUAL]
                   | st_next.full
                   | st_next.enc == rfe_pkg::ENC_SHIFT); // [RULE3] [RULE2]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.enc_cfg <= rfe_pkg::RST_ENC_CFG;  // [RULE9]
      st_reg.control <= rfe_pkg::RST_CONTROL;  // [RULE15]
      st_reg.baud_div <= rfe_pkg::RST_BAUD_DIV;
      st_reg.freq_int <= rfe_pkg::RST_FREQ_INT;
      st_reg.freq_frc <= rfe_pkg::RST_FREQ_FRC;
      st_reg.enc <= rfe_pkg::ENC_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.rdata;
  assign pready           = st_reg.ready;
  assign pslverr          = st_reg.err;
  assign buffer_full_flag = st_reg.full;
  assign shift_end_flag   = st_reg.shift_end;
  assign amp_cut_flag     = st_reg.cut;
  assign mod_data         = st_reg.mod; // [RULE21]
  assign amp_on           = st_reg.amp;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  full_on_load_a: assert property ( // [RULE10]
    (seq_load && !cpu_mode) |=> buffer_full_flag)
    else $error("buffer full not set after load");
  full_clear_a: assert property ( // [RULE22]
    (chip_tick && st_reg.enc == rfe_pkg::ENC_IDLE && st_reg.full
     && !seq_load && !wr) |=> !buffer_full_flag)
    else $error("buffer full not cleared on transfer");
  amp_on_load_a: assert property ( // [RULE2]
    (buffer_full_flag && !amp_cut_flag && !fail) |-> amp_on)
    else $error("amplifier off with byte pending");
  amp_cut_a: assert property ( // [RULE13]
    amp_cut_flag |-> !amp_on)
    else $error("amplifier on while cut");
  cut_status_a: assert property ( // [RULE14]
    (fail && st_reg.enc == rfe_pkg::ENC_SHIFT) |=> amp_cut_flag)
    else $error("cut flag not set on monitor fail");
  amp_auto_off_a: assert property ( // [RULE3]
    (st_reg.enc == rfe_pkg::ENC_IDLE && !buffer_full_flag
     && !st_reg.control[rfe_pkg::CTL_AMP_MANUAL]) |-> !amp_on)
    else $error("amplifier on after transmission");
  tick_only_a: assert property ( // [RULE4]
    (!$past(chip_tick) && st_reg.enc == rfe_pkg::ENC_SHIFT
     && $past(st_reg.enc) == rfe_pkg::ENC_SHIFT) |-> $stable(mod_data))
    else $error("output moved without strobe");
  shift_end_a: assert property ( // [RULE12]
    (chip_tick && st_reg.enc == rfe_pkg::ENC_SHIFT && st_reg.last)
    |=> shift_end_flag)
    else $error("shift end not set");
  idle_level_a: assert property ( // [RULE7]
    (st_reg.enc == rfe_pkg::ENC_IDLE && $past(st_reg.enc)
     == rfe_pkg::ENC_IDLE && st_reg.control[rfe_pkg::CTL_AMP_MANUAL]
     && $stable(st_reg.enc_cfg) && $stable(st_reg.control))
    |-> mod_data == (st_reg.enc_cfg[6] ^ st_reg.enc_cfg[7]))
    else $error("idle level wrong");
  apb_wait_a: assert property (
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");

  byte_sent_c: cover property (
    st_reg.enc == rfe_pkg::ENC_SHIFT ##1 shift_end_flag);
  raw_mode_c: cover property (
    scheme == rfe_pkg::SCH_RAW && st_reg.enc == rfe_pkg::ENC_SHIFT);
  monitor_cut_c: cover property ($rose(amp_cut_flag));

endmodule // rfe_line_encoder

// >>> rfe_pkg.sv
package rfe_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_TX_BYTE  = 8'h00;
  localparam logic [7:0] OFF_ENC_CFG  = 8'h04;
  localparam logic [7:0] OFF_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_BAUD_DIV = 8'h10;
  localparam logic [7:0] OFF_FREQ_INT = 8'h14;
  localparam logic [7:0] OFF_FREQ_FRC = 8'h18;

  // encoder_config fields
  localparam int ENC_SCHEME_LSB = 0;
  localparam int ENC_COUNT_LSB  = 3;
  localparam int ENC_IDLE_BIT   = 6;
  localparam int ENC_INVERT_BIT = 7;

  // tx_control_reg fields
  localparam int CTL_LOCK_MON   = 0;
  localparam int CTL_XTAL_MON   = 1;
  localparam int CTL_AMP_MANUAL = 2;
  localparam int CTL_CPU_MODE   = 3;

  // tx_status_reg fields
  localparam int STS_FULL      = 0;
  localparam int STS_SHIFT_END = 1;
  localparam int STS_AMP_CUT   = 2;
  localparam int STS_LOCK_LOST = 3;
  localparam int STS_XTAL_FAIL = 4;

  // encoding_scheme_sel values
  localparam logic [2:0] SCH_MANCH     = 3'h0;
  localparam logic [2:0] SCH_INV_MANCH = 3'h1;
  localparam logic [2:0] SCH_DIFF      = 3'h2;
  localparam logic [2:0] SCH_BIPH0     = 3'h3;
  localparam logic [2:0] SCH_BIPH1     = 3'h4;
  localparam logic [2:0] SCH_RAW       = 3'h5;

  // reset values
  localparam logic [7:0]  RST_ENC_CFG  = 8'h38;
  localparam logic [3:0]  RST_CONTROL  = 4'h0;
  localparam logic [15:0] RST_BAUD_DIV = 16'h0000;
  localparam logic [7:0]  RST_FREQ_INT = 8'h00;
  localparam logic [20:0] RST_FREQ_FRC = 21'h00000;

  // chip clock is bit clock times two, equal to it in raw mode: chip period 4*(divisor+1)
  localparam int PRESC_BITS = 2;
  localparam int BAUD_W     = 16;
  localparam int FRAC_W     = 21;
  localparam int INT_W      = 8;

  typedef enum logic {
    ENC_IDLE,
    ENC_SHIFT
  } rfe_enc_type;

endpackage

// >>> rfe_baud_gen.sv
`timescale 1ns/1ps
module rfe_baud_gen #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // divisor and chip strobe
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  chip_tick
);

  localparam int CW = DIV_W + rfe_pkg::PRESC_BITS;

  if (DIV_W < 1)
  begin : g_chk
    $error("rfe_baud_gen: DIV_W must be positive");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } rfe_baud_type;

  rfe_baud_type st_reg;
  rfe_baud_type st_next;
  logic [CW-1:0] limit;

  assign limit = {divisor, {rfe_pkg::PRESC_BITS{1'b1}}};

  // chip strobe every 4*(divisor+1) clocks
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= limit)
    begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign chip_tick = st_reg.tick;

endmodule // rfe_baud_gen

// >>> rfe_sd_mod.sv
`timescale 1ns/1ps
module rfe_sd_mod #(
  parameter int INT_W  = 8,
  parameter int FRAC_W = 21
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // frequency word
  input  wire logic [INT_W-1:0]  int_word,
  input  wire logic [FRAC_W-1:0] frac_word,
  // divider ratio stream
  output logic [INT_W:0]         ratio_word
);

  if (INT_W < 1 || FRAC_W < 1)
  begin : g_chk
    $error("rfe_sd_mod: widths must be positive");
  end

  typedef struct packed {
    logic [FRAC_W-1:0] acc;
    logic [INT_W:0]    word;
  } rfe_sd_type;

  rfe_sd_type      st_reg;
  rfe_sd_type      st_next;
  logic [FRAC_W:0] sum;

  // first order accumulator: carry adds one to the ratio
  always_comb
  begin
    st_next = st_reg;
    sum = {1'b0, st_reg.acc} + {1'b0, frac_word};
    st_next.acc = sum[FRAC_W-1:0];
    st_next.word = {1'b0, int_word} + {{INT_W{1'b0}}, sum[FRAC_W]}; // [RULE17]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign ratio_word = st_reg.word;

endmodule // rfe_sd_mod

// >>> rfe_seq_model.sv
`timescale 1ns/1ps
module rfe_seq_model (
  // clock
  input  wire logic       pclk,
  // request from the bench
  input  wire logic       go,
  input  wire logic [7:0] data,
  // byte port of the encoder
  input  wire logic       buffer_full_flag,
  output logic            seq_load,
  output logic [7:0]      seq_byte
);
  initial
  begin
    seq_load = 1'b0;
    seq_byte = 8'h00;
  end

  // one load per request, held back while a byte is pending
  always @(posedge go)
  begin
    @(posedge pclk);
    while (buffer_full_flag !== 1'b0) @(posedge pclk);
    seq_byte <= data;
    seq_load <= 1'b1;
    @(posedge pclk);
    seq_load <= 1'b0;
    seq_byte <= ~data;
  end
endmodule // rfe_seq_model

// >>> tb_rf_tx_line_encoder.sv
`timescale 1ns/1ps
module tb_rf_tx_line_encoder;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, seq_byte, go_byte;
  logic [31:0] pwdata, prdata, q;
  logic        seq_load, buffer_full_flag, shift_end_flag, go, e;
  logic        lock_lost_flag, crystal_fail_flag, mod_data, amp_on;
  logic        amp_cut_flag;
  logic [8:0]  ratio_word;
  logic [15:0] chips, x;
  int          errors, num_checks, cycles, per;

  rfe_line_encoder DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_load(seq_load),
    .seq_byte(seq_byte), .buffer_full_flag(buffer_full_flag),
    .shift_end_flag(shift_end_flag), .lock_lost_flag(lock_lost_flag),
    .crystal_fail_flag(crystal_fail_flag), .mod_data(mod_data),
    .amp_on(amp_on), .amp_cut_flag(amp_cut_flag),
    .ratio_word(ratio_word)
  );

  rfe_seq_model seq (
    .pclk(pclk), .go(go), .data(go_byte),
    .buffer_full_flag(buffer_full_flag), .seq_load(seq_load),
    .seq_byte(seq_byte)
  );

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] v);
    num_checks++;
    if (s !== v)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, v, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      wrap_up();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m, input string n);
    apb(1'b0, a, 32'h0);
    check(n, q & m, v);
  endtask

  task automatic pulse_go(input logic [7:0] b);
    @(posedge pclk);
    go_byte <= b;
    go      <= 1'b1;
    @(posedge pclk);
    go      <= 1'b0;
  endtask

  task automatic wait_full();
    while (buffer_full_flag !== 1'b1) @(negedge pclk);
    check("amp_on", amp_on, 1'b1);
  endtask

  task automatic capture(input int m);
    while (buffer_full_flag !== 1'b0) @(negedge pclk);
    repeat (per + 2) @(negedge pclk);
    check("amp_shift", amp_on, 1'b1);
    chips = '0;
    for (int i = 0; i < m; i++)
    begin
      chips[i] = mod_data;
      repeat (per) @(negedge pclk);
    end
  endtask

  task automatic finish_tx();
    repeat (per + 2) @(negedge pclk);
    check("shift_end", shift_end_flag, 1'b1);
    check("amp_off", amp_on, 1'b0);
    wr(rfe_pkg::OFF_STATUS, 32'h2);
  endtask

  // chip i of the line sits in bit i
  function automatic logic [15:0] expect_chips(input logic [2:0] s,
    input logic [7:0] b, input int nb, input logic inv,
    input logic [15:0] c);
    logic [15:0] r;
    logic        v;
    int          k;
    r = '0;
    for (int i = 0; i < nb; i++)
    begin
      v = b[7-i];
      k = 2 * i;
      case (s)
        rfe_pkg::SCH_RAW:       r[i] = v ^ inv;
        rfe_pkg::SCH_MANCH:     r[k] = v ^ inv;
        rfe_pkg::SCH_INV_MANCH: r[k] = ~v ^ inv;
        rfe_pkg::SCH_DIFF:      r[k] = (i == 0) ? c[k] : c[k-1] ^ ~v;
        default:                r[k] = (i == 0) ? c[k] : ~c[k-1];
      endcase
      if (s == rfe_pkg::SCH_BIPH0)
        r[k+1] = c[k] ^ v;
      else if (s == rfe_pkg::SCH_BIPH1)
        r[k+1] = c[k] ^ ~v;
      else if (s != rfe_pkg::SCH_RAW)
        r[k+1] = ~c[k];
    end
    return r;
  endfunction

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    go_byte = 8'h00;
    lock_lost_flag = 1'b0;
    crystal_fail_flag = 1'b0;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    per = 4;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(rfe_pkg::OFF_ENC_CFG, 32'h38, '1, "enc_cfg");
    rd(rfe_pkg::OFF_CONTROL, 32'h0, '1, "control");
    rd(rfe_pkg::OFF_BAUD_DIV, 32'h0, '1, "baud_div");
    apb(1'b0, 8'h1c, 32'h0);
    check("slverr", e, 1'b1);
    wr(rfe_pkg::OFF_FREQ_INT, 32'h1a5);
    rd(rfe_pkg::OFF_FREQ_INT, 32'ha5, '1, "freq_int");
    wr(rfe_pkg::OFF_FREQ_FRC, 32'hffffffff);
    rd(rfe_pkg::OFF_FREQ_FRC, 32'h1fffff, '1, "freq_frc");
    check("ratio", ratio_word, 32'h0a6);
    $display("test registers done");
    crystal_fail_flag <= 1'b1;
    for (int s = 0; s < 6; s++)
    begin
      wr(rfe_pkg::OFF_ENC_CFG, {24'h0, s[0], 1'b0, 3'h7, s[2:0]});
      check("se_clear", shift_end_flag, 1'b0);
      pulse_go(8'hb4);
      wait_full();
      capture((s == 5) ? 8 : 16);
      check("no_cut", amp_cut_flag, 1'b0);
      x = expect_chips(s[2:0], 8'hb4, 8, s[0], chips);
      check("chips", chips, x);
      finish_tx();
    end
    crystal_fail_flag <= 1'b0;
    $display("test schemes done");
    per = 4 * (1 + 1);
    wr(rfe_pkg::OFF_BAUD_DIV, 32'h1);
    wr(rfe_pkg::OFF_ENC_CFG, 32'h1d);
    wr(rfe_pkg::OFF_CONTROL, 32'h8);
    pulse_go(8'h3c);
    repeat (4) @(negedge pclk);
    check("seq_ignored", buffer_full_flag, 1'b0);
    wr(rfe_pkg::OFF_TX_BYTE, 32'h9c);
    wait_full();
    capture(4);
    x = expect_chips(rfe_pkg::SCH_RAW, 8'h9c, 4, 1'b0, chips);
    check("cpu_chips", chips, x);
    finish_tx();
    $display("test cpu mode done");
    per = 4;
    wr(rfe_pkg::OFF_BAUD_DIV, 32'h0);
    wr(rfe_pkg::OFF_CONTROL, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      wr(rfe_pkg::OFF_ENC_CFG, {24'h0, i[0], i[1], 6'h38});
      repeat (3) @(negedge pclk);
      check("idle", mod_data, i[0] ^ i[1]);
    end
    $display("test idle level done");
    wr(rfe_pkg::OFF_CONTROL, 32'h3);
    for (int k = 0; k < 2; k++)
    begin
      pulse_go(8'h0f);
      wait_full();
      @(posedge pclk);
      lock_lost_flag    <= (k == 0);
      crystal_fail_flag <= (k == 1);
      repeat (4) @(negedge pclk);
      check("amp_cut", amp_on, 1'b0);
      check("cut_flag", amp_cut_flag, 1'b1);
      @(posedge pclk);
      lock_lost_flag    <= 1'b0;
      crystal_fail_flag <= 1'b0;
      repeat (80) @(negedge pclk);
      rd(rfe_pkg::OFF_STATUS, 32'h4, 32'h4, "sts_cut");
      wr(rfe_pkg::OFF_STATUS, 32'h6);
      rd(rfe_pkg::OFF_STATUS, 32'h0, 32'h6, "sts_clr");
    end
    $display("test monitors done");
    wrap_up();
  end
endmodule // tb_rf_tx_line_encoder
